// ==== logic/sfc_config.sv ====
`timescale 1ns/100ps
`include "sfc_defs.svh"
// =====================================================
// first, access, fourth and fifth control word bank with auto power-up
module sfc_config (
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  wire logic              word_strobe,
    input  wire logic [23:0]       word_data,
    input  wire logic              chip_enable,
    input  wire sfc_pkg::sfc_src_s lock_src,
    input  wire logic              ref_input_pin,
    input  wire logic              ref_input_2x,
    output logic                   test_lock_pin_o,
    output logic                   test_lock_pin_oe,
    output logic                   ref_output_pin_o,
    output logic                   ref_output_pin_oe,
    output logic                   if_ref_clk,
    output logic                   rf_ref_clk,
    output sfc_pkg::sfc_cfg_s      cfg,
    output logic                   rf_power_down,
    output logic                   if_power_down,
    output logic                   modulator_enable,
    output logic [21:0]            fraction_numerator,
    output logic [21:0]            fraction_denominator,
    output logic [23:0]            first_control_word
);
    import sfc_pkg::*;
    // =====================================================
    // reset release
    logic rs1_r;
    logic rst_n;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rs1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rst_n <= rs1_r;
        end
    end
    // =====================================================
    // stored control words
    logic [23:0] w0_r, w0_nxt;          // first word, holds power-downs
    logic [23:0] w3_r, w3_nxt;          // access word
    logic [23:0] w4_r, w4_nxt;          // fourth word
    logic [23:0] w5_r, w5_nxt;          // fifth word
    logic [11:0] num_lo;                // base numerator bits
    logic [11:0] den_lo;                // base denominator bits
    logic        ext_mode;              // 22-bit fraction access
    logic [3:0]  addr;                  // word address
    assign addr = word_data[3:0];
    // latch a whole word only on its strobe
    always_comb begin
        w0_nxt = w0_r;
        w3_nxt = w3_r;
        w4_nxt = w4_r;
        w5_nxt = w5_r;
        if (word_strobe) begin
            case (addr)
                `SFC_ADDR_W0: begin
                    w0_nxt = word_data;
                    if (w4_r[`SFC_W4_AUTO_POWER_UP_BIT] && chip_enable) begin
                        w0_nxt[`SFC_W0_PDRF_BIT] = 1'b0;
                        w0_nxt[`SFC_W0_PDIF_BIT] = 1'b0;
                    end
                end
                `SFC_ADDR_W3: w3_nxt = word_data;
                `SFC_ADDR_W4: w4_nxt = word_data;
                `SFC_ADDR_W5: w5_nxt = word_data;
                default: begin
                    w0_nxt = w0_r;
                end
            endcase
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            w0_r <= `SFC_W0_RESET;
            w3_r <= `SFC_W3_RESET;
            w4_r <= `SFC_W4_RESET;
            w5_r <= `SFC_W5_RESET;
        end else begin
            w0_r <= w0_nxt;
            w3_r <= w3_nxt;
            w4_r <= w4_nxt;
            w5_r <= w5_nxt;
        end
    end
    // =====================================================
    // field decode of the fourth word
    always_comb begin
        cfg.auto_power_up      = w4_r[`SFC_W4_AUTO_POWER_UP_BIT];
        cfg.dither_select      = sfc_dither_e'(w4_r[`SFC_W4_DITHER_SELECT_HI:`SFC_W4_DITHER_SELECT_LO]);
        cfg.modulator_order    = sfc_order_e'(w4_r[`SFC_W4_FM_HI:`SFC_W4_FM_LO]);
        cfg.ref_doubler_enable = w4_r[`SFC_W4_DBL_BIT];
        cfg.ref_output_enable  = w4_r[`SFC_W4_OUT_BIT];
        cfg.if_pump_polarity   = w4_r[`SFC_W4_IFP_BIT];
        cfg.rf_pump_polarity   = w4_r[`SFC_W4_RFP_BIT];
        cfg.if_prescaler_16    = w4_r[`SFC_W4_PRE_BIT];
        cfg.test_pin_select    = w4_r[`SFC_W4_SEL_HI:`SFC_W4_SEL_LO];
    end
    // order code one switches the modulator off
    assign modulator_enable = (cfg.modulator_order != SFC_ORD_OFF);
    // =====================================================
    // fraction assembly
    assign ext_mode = w3_r[`SFC_W3_ACC1_BIT];
    assign num_lo = w0_r[15:4];
    assign den_lo = w3_r[15:4];
    always_comb begin
        if (ext_mode) begin
            fraction_numerator   = {w5_r[`SFC_W5_NUM_HI:`SFC_W5_NUM_LO], num_lo};
            fraction_denominator = {w5_r[`SFC_W5_DEN_HI:`SFC_W5_DEN_LO], den_lo};
        end else begin
            fraction_numerator   = {10'h000, num_lo};
            fraction_denominator = {10'h000, den_lo};
        end
    end
    assign rf_power_down = w0_r[`SFC_W0_PDRF_BIT] | ~chip_enable;
    assign if_power_down = w0_r[`SFC_W0_PDIF_BIT] | ~chip_enable;
    assign first_control_word = w0_r;
    // =====================================================
    // reference paths
    assign ref_output_pin_o  = ref_input_pin;
    assign ref_output_pin_oe = cfg.ref_output_enable;
    assign if_ref_clk = ref_input_pin;
    assign rf_ref_clk = cfg.ref_doubler_enable ? ref_input_2x : ref_input_pin;
    // =====================================================
    // test and lock pin
    sfc_pin_s pin;
    sfc_pin_mux u_mux (
        .clock (clock),
        .rst_n (rst_n),
        .sel   (cfg.test_pin_select),
        .src   (lock_src),
        .pin   (pin)
    );
    assign test_lock_pin_o  = pin.o;
    assign test_lock_pin_oe = pin.oe;
    // =====================================================
    // checks
    a_auto_power_up_clears_pd: assert property (@(posedge clock) disable iff (!rst_n)
        (word_strobe && addr == `SFC_ADDR_W0 && w4_r[`SFC_W4_AUTO_POWER_UP_BIT] && chip_enable)
        |=> (w0_r[`SFC_W0_PDRF_BIT] == 1'b0) && (w0_r[`SFC_W0_PDIF_BIT] == 1'b0))
        else $error("auto power-up left power-down set");
    a_ce_inhibits: assert property (@(posedge clock) disable iff (!rst_n)
        (word_strobe && addr == `SFC_ADDR_W0 && !chip_enable)
        |=> w0_r[`SFC_W0_PDRF_BIT] == $past(word_data[`SFC_W0_PDRF_BIT]))
        else $error("power-up with chip enable low");
    a_no_strobe_hold: assert property (@(posedge clock) disable iff (!rst_n)
        !word_strobe |=> $stable(w4_r) && $stable(w5_r))
        else $error("word changed without strobe");
    a_short_fraction: assert property (@(posedge clock) disable iff (!rst_n)
        !ext_mode |-> fraction_numerator[21:12] == 10'h000)
        else $error("upper numerator used in 12-bit mode");
    a_long_fraction: assert property (@(posedge clock) disable iff (!rst_n)
        ext_mode |-> fraction_numerator[21:12] == w5_r[13:4])
        else $error("upper numerator missing");
    a_order_off: assert property (@(posedge clock) disable iff (!rst_n)
        (w4_r[15:14] == 2'h1) |-> !modulator_enable)
        else $error("modulator not disabled");
    a_doubler: assert property (@(posedge clock) disable iff (!rst_n)
        !w4_r[12] |-> (rf_ref_clk == ref_input_pin) && (if_ref_clk == ref_input_pin))
        else $error("doubler path wrong");
    a_ref_out: assert property (@(posedge clock) disable iff (!rst_n)
        ref_output_pin_oe == w4_r[11])
        else $error("reference output enable wrong");
endmodule

// ==== inc/sfc_defs.svh ====
`ifndef SFC_DEFS_SVH
`define SFC_DEFS_SVH
// =====================================================
// control word addresses and field positions
`define SFC_ADDR_W0        4'h0
`define SFC_ADDR_W3        4'h7
`define SFC_ADDR_W4        4'h9
`define SFC_ADDR_W5        4'hb
`define SFC_W3_ACC1_BIT    21
`define SFC_W0_PDRF_BIT    4
`define SFC_W0_PDIF_BIT    5
`define SFC_W4_AUTO_POWER_UP_BIT    23
`define SFC_W4_DITHER_SELECT_HI     17
`define SFC_W4_DITHER_SELECT_LO     16
`define SFC_W4_FM_HI       15
`define SFC_W4_FM_LO       14
`define SFC_W4_DBL_BIT     12
`define SFC_W4_OUT_BIT     11
`define SFC_W4_IFP_BIT     10
`define SFC_W4_RFP_BIT     9
`define SFC_W4_PRE_BIT     8
`define SFC_W4_SEL_HI      7
`define SFC_W4_SEL_LO      4
`define SFC_W5_DEN_HI      23
`define SFC_W5_DEN_LO      14
`define SFC_W5_NUM_HI      13
`define SFC_W5_NUM_LO      4
// reset values (default state of the fourth, fifth, access and first words)
`define SFC_W4_RESET       24'h02c709
`define SFC_W5_RESET       24'h00000b
`define SFC_W3_RESET       24'h000007
`define SFC_W0_RESET       24'h000000
`endif

// ==== inc/sfc_pkg.sv ====
package sfc_pkg;
    // =====================================================
    // modes of the modulator and dither
    typedef enum logic [1:0] {
        SFC_ORD4 = 2'h0,
        SFC_ORD_OFF = 2'h1,
        SFC_ORD2 = 2'h2,
        SFC_ORD3 = 2'h3
    } sfc_order_e;
    typedef enum logic [1:0] {
        SFC_DITHER_SELECT_NONE = 2'h0,
        SFC_DITHER_SELECT_WEAK = 2'h1,
        SFC_DITHER_SELECT_STRONG = 2'h2,
        SFC_DITHER_SELECT_RSVD = 2'h3
    } sfc_dither_e;
    // decoded configuration of the fourth word
    typedef struct packed {
        logic        auto_power_up;
        sfc_dither_e dither_select;
        sfc_order_e  modulator_order;
        logic        ref_doubler_enable;
        logic        ref_output_enable;
        logic        if_pump_polarity;
        logic        rf_pump_polarity;
        logic        if_prescaler_16;
        logic [3:0]  test_pin_select;
    } sfc_cfg_s;
    // lock and divider sources feeding the test pin
    typedef struct packed {
        logic rf_dig_lock;
        logic if_dig_lock;
        logic rf_ana_lock;
        logic if_ana_lock;
        logic if_ref_div;
        logic if_fb_div;
        logic rf_ref_div;
        logic rf_fb_div;
    } sfc_src_s;
    // value and drive enable of the test pin
    typedef struct packed {
        logic o;
        logic oe;
    } sfc_pin_s;
endpackage

// ==== logic/sfc_half_div.sv ====
`timescale 1ns/100ps
`include "sfc_defs.svh"
// =====================================================
// divides a divider pulse stream by two with a toggle
module sfc_half_div (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic pulse,
    output logic      half
);
    logic prev_r;
    logic prev_nxt;
    logic half_r;
    logic half_nxt;
    // toggle on each rising edge of the source
    always_comb begin
        prev_nxt = pulse;
        half_nxt = half_r ^ (pulse & ~prev_r);
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= 1'b0;
            half_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
            half_r <= half_nxt;
        end
    end
    assign half = half_r;
endmodule

// ==== logic/sfc_pin_mux.sv ====
`timescale 1ns/100ps
`include "sfc_defs.svh"
// =====================================================
// test and lock pin source selection
module sfc_pin_mux (
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic [3:0]        sel,
    input  wire sfc_pkg::sfc_src_s src,
    output sfc_pkg::sfc_pin_s      pin
);
    import sfc_pkg::*;
    logic [3:0] half;   // halved divider outputs
    logic [3:0] divs;   // raw divider outputs
    sfc_pin_s   pin_nxt;
    sfc_pin_s   pin_r;
    assign divs = {src.rf_fb_div, src.rf_ref_div, src.if_fb_div, src.if_ref_div};
    // one halver per divider source
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_half
            sfc_half_div u_half (
                .clock (clock),
                .rst_n (rst_n),
                .pulse (divs[gi]),
                .half  (half[gi])
            );
        end
    endgenerate
    // select pin value and drive mode
    always_comb begin
        pin_nxt = '{o: 1'b0, oe: 1'b1};
        case (sel)
            4'h0: pin_nxt.oe = 1'b0;
            4'h1: pin_nxt.o = 1'b1;
            4'h2: pin_nxt.o = 1'b0;
            4'h3: pin_nxt.o = src.rf_dig_lock & src.if_dig_lock;
            4'h4: pin_nxt.o = src.rf_dig_lock;
            4'h5: pin_nxt.o = src.if_dig_lock;
            4'h6: pin_nxt.oe = ~(src.rf_ana_lock & src.if_ana_lock);
            4'h7: pin_nxt.oe = ~src.rf_ana_lock;
            4'h8: pin_nxt.oe = ~src.if_ana_lock;
            4'h9: pin_nxt.o = src.rf_ana_lock & src.if_ana_lock;
            4'ha: pin_nxt.o = src.rf_ana_lock;
            4'hb: pin_nxt.o = src.if_ana_lock;
            default: pin_nxt.o = half[sel[1:0]];
        endcase
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_r <= '{o: 1'b0, oe: 1'b0};
        end else begin
            pin_r <= pin_nxt;
        end
    end
    assign pin = pin_r;
    a_pin_tristate: assert property (@(posedge clock) disable iff (!rst_n)
        (sel == 4'h0) |=> !pin_r.oe) else $error("pin driven in code zero");
    a_pin_opendrain: assert property (@(posedge clock) disable iff (!rst_n)
        (sel == 4'h7) |=> (pin_r.oe == !$past(src.rf_ana_lock)) && !pin_r.o)
        else $error("open drain wrong");
endmodule

// ==== sim/sfc_host.sv ====
`timescale 1ns/100ps
// =====================================
// host side of the serial control link
module sfc_host (
    input  wire logic   clock,
    output logic        word_strobe,
    output logic [23:0] word_data
);
    // bus idle at time zero
    initial begin
        word_strobe = 1'b0;
        word_data   = 24'h000000;
    end
    // whole word held until the taking edge, then the bus is released
    task automatic send(input logic [23:0] w);
        if (w[3:0] == 4'h9 && w[17:16] == 2'h3) begin
            w[17:16] = 2'h2; // reserved dither code never goes out
        end
        @(posedge clock);
        #1 word_strobe = 1'b1;
        word_data = w;
        @(posedge clock);
        #1 word_strobe = 1'b0;
        word_data = ~w; // released bus must not show the stale word
    endtask
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin fails++; \
    $display("BAD %0t %s", $time, m); end end
// =====================================
// bench for the control word bank
module testbench;
    import sfc_pkg::*;
    logic              clock, reset_n, chip_enable, ref_input_pin, ref_input_2x;
    logic              word_strobe, pin_o, pin_oe, ref_o, ref_oe, if_clk, rf_clk;
    logic              rf_power_down, if_power_down, modulator_enable;
    logic [23:0]       word_data, first_control_word;
    logic [21:0]       fraction_numerator, fraction_denominator;
    sfc_src_s          lock_src;
    sfc_cfg_s          cfg;
    int                fails, total_checks;
    sfc_host u_sfc_host (.clock(clock), .word_strobe(word_strobe), .word_data(word_data));
    sfc_config u_sfc_config (.clock(clock), .reset_n(reset_n), .word_strobe(word_strobe),
        .word_data(word_data), .chip_enable(chip_enable), .lock_src(lock_src),
        .ref_input_pin(ref_input_pin), .ref_input_2x(ref_input_2x),
        .test_lock_pin_o(pin_o), .test_lock_pin_oe(pin_oe), .ref_output_pin_o(ref_o),
        .ref_output_pin_oe(ref_oe), .if_ref_clk(if_clk), .rf_ref_clk(rf_clk), .cfg(cfg),
        .rf_power_down(rf_power_down), .if_power_down(if_power_down),
        .modulator_enable(modulator_enable), .fraction_numerator(fraction_numerator),
        .fraction_denominator(fraction_denominator),
        .first_control_word(first_control_word));
    // fields of a fourth word as the bank should decode them
    function automatic sfc_cfg_s cfg_of(input logic [23:0] w);
        return {w[23], w[17:14], w[12:4]};
    endfunction
    // wait n edges, land just after the last one
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // reset state of the fourth word and the pins
    task automatic scen_reset;
        `CHK(cfg, cfg_of(24'h02c709), "cfg reset")
        `CHK(pin_oe, 1'b0, "test pin reset")
        `CHK(ref_oe, 1'b0, "ref out reset")
        `CHK(fraction_numerator, 22'h000000, "num reset")
    endtask
    // every source code of the test pin
    task automatic scen_pin;
        logic rf, ifl, o0;
        for (int c = 0; c < 12; c++) begin
            u_sfc_host.send({16'h0007, c[3:0], 4'h9});
            for (int p = 0; p < 3; p++) begin
                rf = (p != 1);
                ifl = (p != 0);
                lock_src = {rf, ifl, rf, ifl, 4'h0};
                tick(2);
                if (c == 0) `CHK(pin_oe, 1'b0, "pin float")
                else if (c < 3) `CHK({pin_o, pin_oe}, {c == 1, 1'b1}, "pin gpo")
                else if (c < 6) `CHK({pin_o, pin_oe}, {c == 3 ? rf & ifl : c == 4 ? rf : ifl,
                    1'b1}, "digital lock")
                else if (c < 9) `CHK({pin_o, pin_oe},
                    {1'b0, !(c == 6 ? rf & ifl : c == 7 ? rf : ifl)}, "open drain lock")
                else `CHK({pin_o, pin_oe}, {c == 9 ? rf & ifl : c == 10 ? rf : ifl, 1'b1},
                    "analog lock")
            end
        end
        for (int c = 12; c < 16; c++) begin
            lock_src = 8'h00;
            u_sfc_host.send({16'h0007, c[3:0], 4'h9});
            tick(3);
            o0 = pin_o;
            for (int k = 1; k < 3; k++) begin
                lock_src[15 - c] = 1'b1;
                tick(3);
                lock_src[15 - c] = 1'b0;
                tick(3);
                `CHK({pin_o, pin_oe}, {o0 ^ k[0], 1'b1}, "halved divider")
            end
        end
    endtask
    // field decode, reference routing and ignored words
    task automatic scen_fields;
        logic [23:0] w;
        for (int k = 0; k < 4; k++) begin
            w = {6'h00, k == 3 ? 2'h1 : k[1:0], k[1:0], 1'b0, k[0], k[1], ~k[0], k[0],
                k[1], 4'h0, 4'h9};
            u_sfc_host.send(w);
            `CHK(cfg, cfg_of(w), "field decode")
            `CHK(modulator_enable, k != 1, "order")
            for (int r = 0; r < 2; r++) begin
                ref_input_pin = r[0];
                ref_input_2x = ~r[0];
                tick(1);
                `CHK({ref_oe, ref_o, if_clk}, {k[1], r[0], r[0]}, "ref out")
                `CHK(rf_clk, k[0] ? ~r[0] : r[0], "doubler")
            end
        end
        u_sfc_host.send({w[23:4], 4'h5});
        tick(2);
        `CHK(cfg, cfg_of(w), "ignored word")
    endtask
    // auto power-up on the first word
    task automatic scen_power;
        u_sfc_host.send(24'h800709);
        chip_enable = 1'b0;
        u_sfc_host.send(24'h000030);
        `CHK(first_control_word, 24'h000030, "inhibited")
        `CHK({rf_power_down, if_power_down}, 2'h3, "chip enable low")
        chip_enable = 1'b1;
        tick(1);
        `CHK({rf_power_down, if_power_down}, 2'h3, "still down")
        u_sfc_host.send(24'h000030);
        `CHK(first_control_word, 24'h000000, "cleared")
        `CHK({rf_power_down, if_power_down}, 2'h0, "powered")
        u_sfc_host.send(24'h000709);
        u_sfc_host.send(24'h000030);
        `CHK({rf_power_down, if_power_down}, 2'h3, "auto off")
    endtask
    // 12-bit and 22-bit fraction assembly
    task automatic scen_frac;
        u_sfc_host.send(24'h303e87); // denominator 1000 or more with 22-bit access
        u_sfc_host.send({10'h2a5, 10'h155, 4'hb}); // numerator above 4096
        u_sfc_host.send(24'h001230);
        `CHK(fraction_numerator, {10'h155, 12'h123}, "num 22")
        `CHK(fraction_denominator, {10'h2a5, 12'h3e8}, "den 22")
        u_sfc_host.send(24'h103e87);
        `CHK(fraction_numerator, {10'h000, 12'h123}, "num 12")
        `CHK(fraction_denominator, {10'h000, 12'h3e8}, "den 12")
    endtask
    // clock at 50 ns period
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // hang guard
    initial begin
        #2000000;
        fails++;
        give_verdict();
    end
    // main sequence
    initial begin
        reset_n = 1'b0;
        chip_enable = 1'b1;
        ref_input_pin = 1'b0;
        ref_input_2x = 1'b0;
        lock_src = 8'h00;
        fails = 0;
        total_checks = 0;
        repeat (5) @(posedge clock);
        #1 reset_n = 1'b1;
        tick(3);
        scen_reset();
        scen_pin();
        scen_fields();
        scen_power();
        scen_frac();
        give_verdict();
    end
endmodule
